// file: hw/scw_control_word_map.sv
// Serial control word shifter, latch decode and double buffering
`timescale 1ns/1ps
`default_nettype none
module scw_control_word_map
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        ser_clk,
	input  wire logic        ser_data,
	input  wire logic        load_strobe,
	output var  logic [15:0] integer_word,
	output var  logic [11:0] fractional_numerator,
	output var  logic [31:0] prescaler_phase_modulus,
	output var  logic [31:0] reference_and_lock_config,
	output var  logic [31:0] band_clock_and_divider_config,
	output var  logic [31:0] output_stage_config,
	output var  logic [31:0] detect_pin_config,
	output var  logic        word_loaded
);
	// ============================================================
	// Operating notes
	// The serial pins run far slower than clk, so each pin is
	// synchronised, and the clock and strobe rising edges are found in the clk domain.
	// A serial clock high or low phase below two clk periods may
	// be lost; the host must pace its frames to suit.
	// A word is only acted on at the load strobe rise. The low three
	// bits pick the latch, and codes above register 5 are dropped
	// without touching any latch or the load pulse.
	// Held fields wait in a holding stage until register 0 is
	// written, so a whole new setting applies in one step. Fields
	// that are not held take effect on their own write.
	// Register 4 divider select bits are held only while the applied
	// register 2 copy has its buffer enable bit set.
	// There is no documented reset; sys_rst clears every latch to
	// zero, so the host must program all six words after reset.
	// Latched outputs are registered; the load pulse lasts a cycle.
	logic        clk_s;
	logic        data_s;
	logic        le_s;
	logic        clk_d;
	logic        le_d;
	logic [31:0] shift_word;
	logic [31:0] hold_r1;
	logic [31:0] hold_r2;
	logic [31:0] hold_r4;
	logic [31:0] app_r0;
	logic        shift_en;
	logic        load_en;
	logic [2:0]  sel;
	logic [5:0]  wr_hit;

	// ============================================================
	// Pin synchronisers
	scw_sync u_sync_clk
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (ser_clk),
		.q       (clk_s)
	);
	scw_sync u_sync_data
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (ser_data),
		.q       (data_s)
	);
	scw_sync u_sync_le
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (load_strobe),
		.q       (le_s)
	);

	// Merge held and direct bits under a mask
	function automatic logic [31:0] merge
	(
		input logic [31:0] held,
		input logic [31:0] direct,
		input logic [31:0] mask
	);
		merge = (held & mask) | (direct & ~mask);
	endfunction : merge

	// One-hot latch select; codes 110 and 111 select nothing
	function automatic logic [5:0] decode_sel
	(
		input logic [2:0] code
	);
		decode_sel = 6'h00;
		if (code <= scw_pkg::SEL_R5)
			decode_sel[code] = 1'b1;
	endfunction : decode_sel

	// ============================================================
	// Edge detection on synchronised pins
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clk_d <= 1'b0;
			le_d  <= 1'b0;
		end
		else
		begin
			clk_d <= clk_s;
			le_d  <= le_s;
		end
	end

	assign shift_en = clk_s & ~clk_d;
	assign load_en  = le_s & ~le_d;
	assign sel      = shift_word[scw_pkg::SEL_MSB:scw_pkg::SEL_LSB];

	// Write hits exist only in the strobe cycle
	assign wr_hit   = load_en ? decode_sel(sel) : 6'h00;

	// ============================================================
	// Serial shift, MSB first; data is stable by the delayed edge
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			shift_word <= scw_pkg::REG_RESET;
		else if (shift_en)
			shift_word <= {shift_word[30:0], data_s};
	end

	// ============================================================
	// Holding stages: writes to registers 1, 2 and 4 land here first
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold_r1 <= scw_pkg::REG_RESET;
			hold_r2 <= scw_pkg::REG_RESET;
			hold_r4 <= scw_pkg::REG_RESET;
		end
		else if (load_en)
		begin
			unique case (sel)
				scw_pkg::SEL_R1: hold_r1 <= shift_word;
				scw_pkg::SEL_R2: hold_r2 <= shift_word;
				scw_pkg::SEL_R4: hold_r4 <= shift_word;
				default:         ; // Others or 110/111
			endcase
		end
	end

	// ============================================================
	// Register 0 latch and transfer of held fields
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			app_r0                    <= scw_pkg::REG_RESET;
			prescaler_phase_modulus   <= scw_pkg::REG_RESET;
			reference_and_lock_config <= scw_pkg::REG_RESET;
			word_loaded               <= 1'b0;
		end
		else
		begin
			word_loaded <= |wr_hit;
			if (wr_hit[0])
			begin
				app_r0                    <= shift_word;
				prescaler_phase_modulus   <= hold_r1;
				reference_and_lock_config <= hold_r2;
			end
			else if (wr_hit[1])
				prescaler_phase_modulus <= merge(prescaler_phase_modulus,
					shift_word, scw_pkg::R1_HELD_MASK);
			else if (wr_hit[2])
				reference_and_lock_config <= merge(reference_and_lock_config,
					shift_word, scw_pkg::R2_HELD_MASK);
		end
	end

	// ============================================================
	// Register 4: divider select held only when buffering is on
	// A register 0 write applies the whole held word, so bits
	// written while buffering was off are simply applied again.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			output_stage_config <= scw_pkg::REG_RESET;
		else if (wr_hit[0])
			output_stage_config <= hold_r4;
		else if (wr_hit[4])
		begin
			// Buffer enable read from the applied register 2 copy
			if (reference_and_lock_config[scw_pkg::DIV_BUF_EN_BIT])
				output_stage_config <= merge(output_stage_config,
					shift_word, scw_pkg::R4_COND_MASK);
			else
				output_stage_config <= shift_word;
		end
	end

	// ============================================================
	// Registers 3 and 5 take effect at once
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			band_clock_and_divider_config <= scw_pkg::REG_RESET;
			detect_pin_config             <= scw_pkg::REG_RESET;
		end
		else if (wr_hit[3])
			band_clock_and_divider_config <= shift_word;
		else if (wr_hit[5])
			detect_pin_config <= shift_word;
	end

	// ============================================================
	// Register 0 field split for the modulator
	assign integer_word =
		app_r0[scw_pkg::INT_MSB:scw_pkg::INT_LSB];
	assign fractional_numerator =
		app_r0[scw_pkg::FRACTIONAL_NUMERATOR_MSB:scw_pkg::FRACTIONAL_NUMERATOR_LSB];
endmodule : scw_control_word_map
`default_nettype wire

// file: hw/scw_pkg.sv
// Package of constants for the serial control word register map
// ============================================================
// Operation
// - Select 000 loads register 0 latch
// - Register 0 bits 30:15 are integer word
// - Register 0 bits 14:3 are fractional numerator
// - Held fields apply on next register 0 write
// - Divider select held only when buffer enabled
// - Shift 32 bits MSB first on clock rise
// - Load strobe rise transfers word to latch
// - Select bits 2:0 choose registers 0..5
package scw_pkg;
	localparam int WORD_W = 32;
	localparam int NUM_REGS = 6;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 2;
	// Select codes
	localparam logic [2:0] SEL_R0 = 3'h0;
	localparam logic [2:0] SEL_R1 = 3'h1;
	localparam logic [2:0] SEL_R2 = 3'h2;
	localparam logic [2:0] SEL_R3 = 3'h3;
	localparam logic [2:0] SEL_R4 = 3'h4;
	localparam logic [2:0] SEL_R5 = 3'h5;
	// Register 0 fields
	localparam int INT_MSB = 30;
	localparam int INT_LSB = 15;
	localparam int FRACTIONAL_NUMERATOR_MSB = 14;
	localparam int FRACTIONAL_NUMERATOR_LSB = 3;
	// Held masks: register 1 phase and modulus
	localparam logic [31:0] R1_HELD_MASK = 32'h07FF_FFF8;
	// Register 2: doubler, halver, R counter, pump current
	localparam logic [31:0] R2_HELD_MASK = 32'h03FF_DE00;
	// Register 2 divider buffer enable bit
	localparam int DIV_BUF_EN_BIT = 13;
	// Register 4 conditionally held divider select
	localparam logic [31:0] R4_COND_MASK = 32'h0070_0000;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage : scw_pkg

// file: hw/scw_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module scw_sync
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic d,
	output var  logic q
);
	logic meta;

	// ============================================================
	// Synchroniser chain; meta feeds only q
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta <= 1'b0;
			q    <= 1'b0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : scw_sync
`default_nettype wire

// file: verification/scw_chk.sv
// Port checker for the control word map
`timescale 1ns/1ps
`default_nettype none
module scw_chk
(
	input wire logic	clk,
	input wire logic	sys_rst,
	input wire logic	load_strobe,
	input wire logic [15:0]	integer_word,
	input wire logic [31:0]	prescaler_phase_modulus,
	input wire logic [31:0]	reference_and_lock_config,
	input wire logic [31:0]	band_clock_and_divider_config,
	input wire logic [31:0]	output_stage_config,
	input wire logic [31:0]	detect_pin_config,
	input wire logic	word_loaded
);
	// ==========
	// Load pulse and latch routing
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_pulse_one: assert property (word_loaded |=> !word_loaded)
		else $error("load pulse longer than one cycle");
	a_strobe_cause: assert property (!load_strobe [*6] |-> !word_loaded)
		else $error("load without strobe");
	a_int_cause: assert property ($changed(integer_word) |-> word_loaded)
		else $error("integer word changed without load");
	a_r1_code: assert property (
		$changed(prescaler_phase_modulus) |->
		prescaler_phase_modulus[2:0] == 3'h1)
		else $error("register 1 took a foreign word");
	a_r2_code: assert property (
		$changed(reference_and_lock_config) |->
		reference_and_lock_config[2:0] == 3'h2)
		else $error("register 2 took a foreign word");
	a_r3_code: assert property (
		$changed(band_clock_and_divider_config) |->
		band_clock_and_divider_config[2:0] == 3'h3)
		else $error("register 3 took a foreign word");
	a_r4_code: assert property (
		$changed(output_stage_config) |->
		output_stage_config[2:0] == 3'h4)
		else $error("register 4 took a foreign word");
	a_r5_code: assert property (
		$changed(detect_pin_config) |->
		detect_pin_config[2:0] == 3'h5)
		else $error("register 5 took a foreign word");
endmodule : scw_chk
bind scw_control_word_map scw_chk scw_chk_inst (.*);
`default_nettype wire

// file: verification/scw_host.sv
// Host model driving the three-wire programming pins
`timescale 1ns/1ps
`default_nettype none
module scw_host
(
	input  wire logic	clk,
	output var logic	ser_clk,
	output var logic	ser_data,
	output var logic	load_strobe
);
	// ==========
	// Pins start low; link clock stands still between frames
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
	end
	// One frame at 200 ns per bit, pins moved on clk rises
	task automatic send(logic [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			ser_data <= w[i];
			repeat (4) @(posedge clk);
			ser_clk <= 1'b1;
			repeat (4) @(posedge clk);
			ser_clk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		load_strobe <= 1'b1;
		repeat (8) @(posedge clk);
		load_strobe <= 1'b0;
		ser_data <= ~ser_data; // Released line never keeps last bit
		repeat (4) @(posedge clk);
	endtask : send
endmodule : scw_host
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the control word map
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic		clk = 1'b0;
	logic		sys_rst = 1'b1;
	logic		ser_clk, ser_data, load_strobe, word_loaded;
	logic [15:0]	integer_word;
	logic [11:0]	fractional_numerator;
	logic [31:0]	q1, q2, q3, q4, q5;
	logic [31:0]	ap [6] = '{default: 32'h0};
	logic [31:0]	hd [6] = '{default: 32'h0};
	logic [31:0]	cw [8] = '{32'h0000_2002, 32'h0070_0004,
		32'h0800_8011, 32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'h0025_8008,
		32'h0000_0002, 32'h0050_0004};
	int		fails = 0, num_checks = 0, cyc = 0, nld = 0, xld = 0;
	// ==========
	// Clock, load counter and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (word_loaded === 1'b1) nld <= nld + 1;
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end
	scw_control_word_map scw_control_word_map_inst (.clk, .sys_rst, .ser_clk,
		.ser_data, .load_strobe, .integer_word, .fractional_numerator,
		.prescaler_phase_modulus(q1), .reference_and_lock_config(q2),
		.band_clock_and_divider_config(q3), .output_stage_config(q4),
		.detect_pin_config(q5), .word_loaded);
	scw_host scw_host_inst (.clk, .ser_clk, .ser_data, .load_strobe);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Held bits per latch; register 4 follows applied buffer enable
	function automatic logic [31:0] msk(logic [2:0] k);
		if (k == 3'h1) return scw_pkg::R1_HELD_MASK;
		if (k == 3'h2) return scw_pkg::R2_HELD_MASK;
		if (k == 3'h4 && ap[2][13]) return scw_pkg::R4_COND_MASK;
		return 32'h0;
	endfunction : msk
	// Send one word, advance the expected latches, compare all latched outputs
	task automatic wr(logic [31:0] w);
		logic [2:0] k;
		k = w[2:0];
		scw_host_inst.send(w);
		if (k < 3'h6)
		begin
			xld++;
			hd[k] = w;
			ap[k] = (ap[k] & msk(k)) | (w & ~msk(k));
			if (k == 3'h0)
			begin
				ap[1] = hd[1];
				ap[2] = hd[2];
				ap[4] = hd[4];
			end
		end
		chk("int", {16'h0, integer_word}, {16'h0, ap[0][30:15]});
		chk("fractional_numerator", {20'h0, fractional_numerator}, {20'h0, ap[0][14:3]});
		chk("r1", q1, ap[1]);
		chk("r2", q2, ap[2]);
		chk("r3", q3, ap[3]);
		chk("r4", q4, ap[4]);
		chk("r5", q5, ap[5]);
	endtask : wr
	task automatic final_report;
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// Corner words first, then random traffic over all select codes
	initial
	begin
		logic [31:0] w;
		void'($urandom(88528));
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (cw[i]) wr(cw[i]);
		repeat (40)
		begin
			w = $urandom;
			w[31] = 1'b0;
			if (w[30:15] < 16'h004B) w[30] = 1'b1;
			if (w[2:0] == 3'h0 && w[14:3] >= ap[1][14:3])
				w[14:3] = 12'h000;
			wr(w);
		end
		chk("loads", 32'(nld), 32'(xld));
		final_report();
	end
endmodule : tb
`default_nettype wire
